// >>> hdl/timer_counter.sv
`include "timer_params.svh"

// How it works
// - eight-bit count wraps FFh to 00h and each wrap sets overflow flag
// - overflow request reaches irq output only while enable bit is set
// - counter and its prescaler stop while the processor sleeps
// - source bit 0 counts one per instruction cycle
// - source bit 1 counts transitions of the external count pin
// - edge bit 0 counts rising pin edges, 1 counts falling edges
// - assignment bit 0 gives prescaler to counter, 1 to watchdog
// - counter ratio is two to the power of rate plus one
// - watchdog ratio is two to the rate; counter then runs undivided
// - one prescaler, one user, count hidden from software
// - count write holds off increments for two instruction cycles
// - count write loads at once and empties the prescaler when counter owns it
// - with divide-by-two, no advance for three counter clocks after write
// - irq output resampled once per instruction cycle at first phase
// - option bit 7 disables port weak pull-ups
// - option bit 6 picks external interrupt edge, 1 rising
// - pin edges synchronised to hclk through two flops before counting
// - watchdog clear empties prescaler when watchdog owns it
module timer_counter #(
  parameter int COUNT_W    = 8,
  parameter int PRESCALE_W = 8
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        ext_count_input,
  input  wire logic        sleep_active,
  input  wire logic        watchdog_base_tick,
  input  wire logic        watchdog_clear_instr,
  output logic             overflow_irq,
  output logic             watchdog_tick,
  output logic             pullup_disable,
  output logic             ext_int_edge,
  output logic             instr_clock_out
);

  if (COUNT_W != 8) begin : g_bad_count
    $error("count width must be 8");
  end
  if (PRESCALE_W != 8) begin : g_bad_prescale
    $error("prescaler width must be 8");
  end
  if (`TCY_CLKS < 2) begin : g_bad_tcy
    $error("instruction cycle needs two clocks or more");
  end

  localparam int PH_W = $clog2(`TCY_CLKS);

  // ----------------------------------------------------------------
  // instruction cycle phases
  // ----------------------------------------------------------------
  logic [PH_W-1:0] phase_q;
  logic            q1;

  assign q1 = (phase_q == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= '0;
    end else if (phase_q == PH_W'(`TCY_CLKS - 1)) begin
      phase_q <= '0;
    end else begin
      phase_q <= phase_q + PH_W'(1);
    end
  end

  // instruction clock visible low in first half of each cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr_clock_out <= 1'b0;
    end else begin
      instr_clock_out <= (phase_q >= PH_W'(`TCY_CLKS / 2 - 1)) &&
                         (phase_q != PH_W'(`TCY_CLKS - 1));
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  timer_pkg::ahb_addr_t aph_q;
  logic                 wr_pend_q;
  logic                 rd_pend_q;
  logic                 take;
  logic                 wr_timer;
  logic                 wr_option;
  logic                 wr_intctl;

  // only whole-word transfers are expected; hsize is not decoded
  // upper address bits ignored, registers alias every 256 bytes
  assign take = hsel & hready & (htrans == `HTRANS_NONSEQ);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_q     <= '0;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take & hwrite;
      if (take) begin
        aph_q.write <= hwrite;
        aph_q.addr  <= haddr[`DEC_W-1:0];
      end
    end
  end

  assign wr_timer  = wr_pend_q & (aph_q.addr == `OFS_TIMER_COUNT);
  assign wr_option = wr_pend_q & (aph_q.addr == `OFS_OPTION_CONFIG);
  assign wr_intctl = wr_pend_q & (aph_q.addr == `OFS_INT_CONTROL);

  // reads take one wait state so data reflects any preceding write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
    end else if (take & ~hwrite) begin
      rd_pend_q <= 1'b1;
      hreadyout <= 1'b0;
    end else begin
      rd_pend_q <= 1'b0;
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp <= `HRESP_OKAY;
    end else begin
      hresp <= `HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [COUNT_W-1:0]      timer_count_q;
  timer_pkg::option_t      option_config_q;
  timer_pkg::int_control_t int_control_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      option_config_q <= `OPTION_RESET;
    end else if (wr_option) begin
      option_config_q <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_pend_q) begin
      unique case (aph_q.addr)
        `OFS_TIMER_COUNT:   hrdata <= {24'h000000, timer_count_q};
        `OFS_OPTION_CONFIG: hrdata <= {24'h000000, option_config_q};
        `OFS_INT_CONTROL:   hrdata <= {24'h000000, int_control_q};
        default:            hrdata <= '0;
      endcase
    end
  end

  // pass-through configuration outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pullup_disable <= 1'(`OPTION_RESET >> `BIT_PULLUP_DIS);
      ext_int_edge   <= 1'(`OPTION_RESET >> `BIT_EXT_INT_EDGE);
    end else begin
      pullup_disable <= option_config_q.pullup_disable;
      ext_int_edge   <= option_config_q.ext_int_edge;
    end
  end

  // ----------------------------------------------------------------
  // write inhibit
  // ----------------------------------------------------------------
  logic [1:0] inhibit_q;
  logic       run;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inhibit_q <= 2'd0;
    end else if (wr_timer) begin
      inhibit_q <= `WRITE_INHIBIT_TCY;
    end else if (q1 && inhibit_q != 2'd0) begin
      inhibit_q <= inhibit_q - 2'd1;
    end
  end

  // run low holds off counting and counter-owned prescaling
  assign run = ~sleep_active & (inhibit_q == 2'd0);

  // ----------------------------------------------------------------
  // source selection and prescaler
  // ----------------------------------------------------------------
  logic                     ext_edge;
  logic                     src_pulse;
  logic                     ps_tick;
  logic                     count_inc;
  logic                     to_watchdog;
  timer_pkg::prescale_ctl_t ps_ctl;

  count_edge_sync u_sync (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .pin_in      (ext_count_input),
    .falling_sel (option_config_q.ext_edge_select),
    .edge_pulse  (ext_edge)
  );

  assign to_watchdog = option_config_q.prescale_assign;
  assign src_pulse   = option_config_q.count_source_select ?
                       ext_edge : q1;

  // watchdog keeps its prescaler running through sleep
  always_comb begin
    if (to_watchdog) begin
      ps_ctl.pulse    = watchdog_base_tick;
      ps_ctl.clear    = watchdog_clear_instr;
      ps_ctl.exponent = {1'b0, option_config_q.prescale_rate};
    end else begin
      ps_ctl.pulse    = src_pulse & run;
      ps_ctl.clear    = wr_timer;
      ps_ctl.exponent = {1'b0, option_config_q.prescale_rate}
                        + 4'd1;
    end
  end

  // one prescaler, steered by the assignment bit
  shared_prescaler #(
    .WIDTH (PRESCALE_W)
  ) u_prescaler (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ctl     (ps_ctl),
    .tick    (ps_tick)
  );

  assign count_inc = to_watchdog ? (src_pulse & run)
                                 : ps_tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_tick <= 1'b0;
    end else begin
      watchdog_tick <= to_watchdog & ps_tick;
    end
  end

  // ----------------------------------------------------------------
  // count and overflow
  // ----------------------------------------------------------------
  logic wrap;

  // a count write beats a same-cycle increment, no flag then
  assign wrap = count_inc & ~wr_timer & (&timer_count_q);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_count_q <= `TIMER_RESET;
    end else if (wr_timer) begin
      timer_count_q <= hwdata[COUNT_W-1:0];
    end else if (count_inc) begin
      timer_count_q <= timer_count_q + COUNT_W'(1);
    end
  end

  // hardware set wins over a same-cycle software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_control_q <= `INT_CONTROL_RESET;
    end else begin
      if (wr_intctl) begin
        int_control_q.overflow_irq_enable <= hwdata[`BIT_OVF_EN];
        int_control_q.overflow_flag       <= hwdata[`BIT_OVF_FLAG];
      end
      if (wrap) begin
        int_control_q.overflow_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq <= 1'b0;
    end else if (q1) begin
      overflow_irq <= int_control_q.overflow_flag &
                      int_control_q.overflow_irq_enable;
    end
  end

endmodule

// >>> hdl/timer_params.svh
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     10
`define TCY_NS            40
`define TCY_CLKS          (`TCY_NS / `CLK_PERIOD_NS)
`define WRITE_INHIBIT_TCY 2'd2

// ----------------------------------------------------------------
// register map, byte offsets within the slave
// ----------------------------------------------------------------
`define DEC_W             8
`define OFS_TIMER_COUNT   8'h00
`define OFS_OPTION_CONFIG 8'h04
`define OFS_INT_CONTROL   8'h08

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TIMER_RESET       8'h00
`define OPTION_RESET      8'hFF
`define INT_CONTROL_RESET 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_OVF_FLAG      2
`define BIT_OVF_EN        5
`define BIT_PULLUP_DIS    7
`define BIT_EXT_INT_EDGE  6
`define BIT_SRC_SELECT    5
`define BIT_EDGE_SELECT   4
`define BIT_PRESCALE_ASG  3

// ----------------------------------------------------------------
// bus encodings
// ----------------------------------------------------------------
`define HTRANS_NONSEQ     2'h2
`define HRESP_OKAY        1'b0

`endif

// >>> hdl/timer_pkg.sv
package timer_pkg;

  // option register layout, msb first
  typedef struct packed {
    logic       pullup_disable;
    logic       ext_int_edge;
    logic       count_source_select;
    logic       ext_edge_select;
    logic       prescale_assign;
    logic [2:0] prescale_rate;
  } option_t;

  // interrupt control layout, unused bits read zero
  typedef struct packed {
    logic [1:0] rsvd_hi;
    logic       overflow_irq_enable;
    logic [1:0] rsvd_mid;
    logic       overflow_flag;
    logic [1:0] rsvd_lo;
  } int_control_t;

  // captured address phase
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
  } ahb_addr_t;

  // prescaler steering
  typedef struct packed {
    logic       pulse;
    logic       clear;
    logic [3:0] exponent;
  } prescale_ctl_t;

endpackage

// >>> hdl/count_edge_sync.sv
// ----------------------------------------------------------------
// pin synchroniser and counting-edge detector
// ----------------------------------------------------------------
module count_edge_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic pin_in,
  input  wire logic falling_sel,
  output logic      edge_pulse
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      edge_pulse <= 1'b0;
    end else begin
      edge_pulse <= falling_sel ? (last_q & ~sync_q)
                                : (~last_q & sync_q);
    end
  end

endmodule

// >>> hdl/shared_prescaler.sv
// ----------------------------------------------------------------
// shared synchronous prescaler, binary ratio 2**exponent
// ----------------------------------------------------------------
module shared_prescaler #(
  parameter int WIDTH = 8
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire timer_pkg::prescale_ctl_t ctl,
  output logic                          tick
);

  if (WIDTH < 1 || WIDTH > 15) begin : g_bad_width
    $error("prescaler width out of range");
  end

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] mask;

  // low exponent bits all ones means the next pulse completes a period
  assign mask = WIDTH'((16'h0001 << ctl.exponent) - 16'h0001);
  assign tick = ctl.pulse & ~ctl.clear & ((cnt_q & mask) == mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (ctl.clear) begin
      cnt_q <= '0;
    end else if (ctl.pulse) begin
      cnt_q <= cnt_q + WIDTH'(1);
    end
  end

endmodule

// >>> tb/timer_counter_sva.sv
`include "timer_params.svh"

// ----
// port checks
// ----
module timer_counter_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        overflow_irq,
  input wire logic        watchdog_tick,
  input wire logic        pullup_disable,
  input wire logic        ext_int_edge,
  input wire logic        instr_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire logic  take = hsel && hready && (htrans == 2'h2);
  logic       wr_q;
  logic       en_q;
  logic [7:0] ofs_q;
  logic [7:0] opt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'h0;
      ofs_q <= 8'h00;
    end else begin
      wr_q  <= take && hwrite;
      ofs_q <= haddr[7:0];
    end
  end

  // software view of option and enable bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opt_q <= 8'hFF;
      en_q  <= 1'h0;
    end else if (wr_q && ofs_q == `OFS_OPTION_CONFIG) begin
      opt_q <= hwdata[7:0];
    end else if (wr_q && ofs_q == `OFS_INT_CONTROL) begin
      en_q <= hwdata[5];
    end
  end

  sequence rd_req;
    take && !hwrite;
  endsequence
  sequence rd_data;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_read_wait: assert property (rd_req |=> rd_data)
    else $error("read wait state wrong");
  chk_read_upper: assert property (
    rd_req ##1 rd_data |-> hrdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_pullup_level: assert property (
    $stable(opt_q) [*2] |-> pullup_disable == opt_q[7])
    else $error("pull-up level differs from option");
  chk_int_edge: assert property (
    $stable(opt_q) [*2] |-> ext_int_edge == opt_q[6])
    else $error("int edge differs from option");
  chk_wd_owner: assert property (
    watchdog_tick |-> opt_q[3] || $past(opt_q[3]) || $past(opt_q[3], 2))
    else $error("watchdog tick while counter owns prescaler");
  chk_irq_masked: assert property (
    !en_q [*6] |-> !overflow_irq)
    else $error("irq while disabled");
  chk_irq_held: assert property (
    $changed(overflow_irq) |=> $stable(overflow_irq) [*3])
    else $error("irq changed inside instruction cycle");
  chk_clk_period: assert property (
    $rose(instr_clock_out) |=> instr_clock_out ##1 !instr_clock_out [*2]
      ##1 instr_clock_out)
    else $error("instruction clock not four cycles");
endmodule

bind timer_counter timer_counter_sva u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hrdata, .overflow_irq, .watchdog_tick, .pullup_disable,
  .ext_int_edge, .instr_clock_out
);

// >>> tb/pulse_source.sv
// ----
// pin pulse train source
// ----
module pulse_source (
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic [7:0] n,
  input  wire logic [7:0] half,
  input  wire logic       idle,
  output logic            pin,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pin  = 1'h0;
    busy = 1'h0;
  end
  // half of two or more keeps each level at least two cycles
  always @(posedge hclk) begin
    if (go && !busy) begin
      busy <= 1'h1;
      repeat (n) begin
        pin <= !idle;
        repeat (half) @(posedge hclk);
        pin <= idle;
        repeat (half) @(posedge hclk);
      end
      busy <= 1'h0;
    end else begin
      pin <= idle;
    end
  end
endmodule

// >>> tb/eight_bit_timer_counter_test.sv
`include "timer_params.svh"
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); \
  end \
end

module eight_bit_timer_counter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'h0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp, go, idle, busy;
  logic        pin, sleep, base, clr, irq, wd_tick, pull, int_edge, iclk;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  n, half;
  int          fail_count = 0, n_checks = 0, wd_n = 0;

  timer_counter u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .ext_count_input(pin), .sleep_active(sleep),
    .watchdog_base_tick(base), .watchdog_clear_instr(clr),
    .overflow_irq(irq), .watchdog_tick(wd_tick), .pullup_disable(pull),
    .ext_int_edge(int_edge), .instr_clock_out(iclk)
  );
  pulse_source u_src (.hclk, .go, .n, .half, .idle, .pin, .busy);

  always #5 hclk = ~hclk;
  always @(negedge hclk) if (wd_tick === 1'h1) wd_n++;

  // ----
  // bus tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= 1'h1;
    haddr  <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge hclk); while (hreadyout !== 1'h1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= 1'h0;
    haddr  <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    d = hrdata[7:0];
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK("register", e, d)
  endtask

  task automatic optchk(input logic [7:0] v);
    wr(`OFS_OPTION_CONFIG, v);
    repeat (3) @(posedge hclk);
    `CHK("pull-up", v[7], pull)
    `CHK("int edge", v[6], int_edge)
    rchk(`OFS_OPTION_CONFIG, v);
  endtask

  // count advance across a window of w cycles
  task automatic span(input logic [7:0] o, input int w, input logic [7:0] e);
    logic [7:0] a, b;
    wr(`OFS_OPTION_CONFIG, o);
    rd(`OFS_TIMER_COUNT, a);
    repeat (w - 4) @(posedge hclk);
    rd(`OFS_TIMER_COUNT, b);
    `CHK("advance", e, 8'(b - a))
  endtask

  task automatic wchk(input logic [7:0] o, input logic [7:0] lo);
    logic [7:0] d;
    wr(`OFS_OPTION_CONFIG, o);
    wr(`OFS_TIMER_COUNT, 8'h10);
    rchk(`OFS_TIMER_COUNT, 8'h10);
    repeat (32) @(posedge hclk);
    rd(`OFS_TIMER_COUNT, d);
    `CHK("after write", 1'h1, d == 8'h10 + lo || d == 8'h11 + lo)
  endtask

  task automatic pin_chk(input logic [7:0] o, input logic v,
                         input logic [7:0] c, input logic [7:0] e);
    logic [7:0] a, b;
    wr(`OFS_OPTION_CONFIG, o);
    rd(`OFS_TIMER_COUNT, a);
    @(posedge hclk);
    idle <= v;
    n    <= c;
    half <= 8'h03;
    repeat (4) @(posedge hclk);
    go   <= c != 8'h00;
    @(posedge hclk);
    go <= 1'h0;
    repeat (12) @(posedge hclk);
    while (busy === 1'h1) @(posedge hclk);
    repeat (8) @(posedge hclk);
    rd(`OFS_TIMER_COUNT, b);
    `CHK("pin count", e, 8'(b - a))
  endtask

  task automatic wd_run(input logic [7:0] o, input int pre, input int p,
                        input int e);
    wr(`OFS_OPTION_CONFIG, o);
    repeat (pre) begin
      @(posedge hclk);
      base <= 1'h1;
      @(posedge hclk);
      base <= 1'h0;
    end
    @(posedge hclk);
    clr <= 1'h1;
    @(posedge hclk);
    clr <= 1'h0;
    wd_n = 0;
    repeat (p) begin
      @(posedge hclk);
      base <= 1'h1;
      @(posedge hclk);
      base <= 1'h0;
    end
    repeat (6) @(posedge hclk);
    `CHK("watchdog ticks", e, wd_n)
  endtask

  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    finish_test();
  end

  // ----
  // main sequence
  // ----
  initial begin
    {hresetn, hwrite, go, idle, sleep, base, clr} = 7'h00;
    {hsel, hsize, htrans, n, half} = {1'h1, 3'h2, 2'h0, 16'h0000};
    {haddr, hwdata} = 64'h0000000000000000;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    rchk(`OFS_TIMER_COUNT, 8'h00);
    rchk(`OFS_OPTION_CONFIG, 8'hFF);
    rchk(`OFS_INT_CONTROL, 8'h00);
    `CHK("pull-up", 1'h1, pull)
    wr(8'h0C, 8'hFF);
    rchk(8'h0C, 8'h00);
    optchk(8'h48);
    optchk(8'h88);
    span(8'h08, 40, 8'h0A);
    for (int r = 0; r < 8; r++) span(8'(r), 16 << r, 8'h02);
    sleep <= 1'h1;
    span(8'h08, 40, 8'h00);
    sleep <= 1'h0;
    wchk(8'h08, 8'h07);
    wchk(8'h00, 8'h03);
    pin_chk(8'h28, 1'h0, 8'h05, 8'h05);
    pin_chk(8'h20, 1'h0, 8'h08, 8'h04);
    pin_chk(8'h28, 1'h1, 8'h00, 8'h01);
    pin_chk(8'h28, 1'h0, 8'h00, 8'h00);
    pin_chk(8'h38, 1'h1, 8'h05, 8'h05);
    pin_chk(8'h38, 1'h0, 8'h00, 8'h01);
    wr(`OFS_OPTION_CONFIG, 8'h08);
    wr(`OFS_INT_CONTROL, 8'h00);
    wr(`OFS_TIMER_COUNT, 8'hFE);
    repeat (40) @(posedge hclk);
    rchk(`OFS_INT_CONTROL, 8'h04);
    `CHK("irq", 1'h0, irq)
    wr(`OFS_INT_CONTROL, 8'h24);
    repeat (8) @(posedge hclk);
    `CHK("irq", 1'h1, irq)
    wr(`OFS_INT_CONTROL, 8'h20);
    repeat (8) @(posedge hclk);
    `CHK("irq", 1'h0, irq)
    for (int r = 0; r < 4; r++) wd_run(8'h08 | 8'(r), 0, 16, 16 >> r);
    wd_run(8'h0B, 5, 4, 0);
    wd_run(8'h00, 0, 16, 0);
    finish_test();
  end
endmodule
